/* src/cms_regs.sv */
/*
  Comparator 1 mode register and comparator 0 input select register.
  Assumes a synchronous register bus on core_clk_in; flags and the other
  comparator's selects arrive from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module cms_regs
  import cms_pkg::*;
(
  // Clock and reset.
  input  wire logic       core_clk_in,
  input  wire logic       nrst_in,
  // Register bus.
  input  wire logic [7:0] addr_in,
  input  wire logic       wr_in,
  input  wire logic [7:0] wdata_in,
  output var  logic [7:0] rdata_out,
  // Comparator 1 edge flags, the other comparator's selects and the timer route.
  input  wire logic       cmp1_rise_flag_in,
  input  wire logic       cmp1_fall_flag_in,
  input  wire logic [7:0] cmp1_sel_in,
  input  wire logic [1:0] timer_route_in,
  // Analog and timer controls.
  output var  logic [7:0] cmp1_mode_reg_out,
  output var  logic [7:0] cmp0_input_sel_reg_out,
  output var  logic       cmp1_irq_out,
  output var  logic       half_div_en_out,
  output var  logic       touch_pos_out,
  output var  logic       touch_neg_out,
  output var  logic [1:0] timer_route_out,
  output var  logic [3:0] pos_pin_out,
  output var  logic [3:0] neg_pin_out
);
  cms_state_t s_q;
  cms_state_t s_d;

  // Refuses mode constants whose fixed-one bit could be written away or is missing after reset.
  if (((CMS_MODE1_WMASK & CMS_MODE1_FIXED1) != 8'h00)
      || ((CMS_MODE1_RESET & CMS_MODE1_FIXED1) != CMS_MODE1_FIXED1))
  begin : g_const_check
    $error("Mode register constants inconsistent.");
  end

  // Decodes a select code into its route; the negative side has an extra reserved code.
  function automatic cms_route_t decode(input logic [3:0] c, input logic neg);
    cms_route_t r;
    r.pin     = (c <= CMS_SEL_PIN_MAX) && !(neg && c == CMS_NEG_RSV);
    r.pin_idx = c[2:0];
    r.touch   = (c == CMS_SEL_TOUCH);
    r.half    = (c == CMS_SEL_HALF);
    r.rsvd    = !r.pin && (c < CMS_SEL_TOUCH);
    return r;
  endfunction

  // Next-state logic: masked mode write, unmasked select write, read mux and decoded controls.
  always_comb
  begin
    s_d = s_q;
    if (wr_in && addr_in == CMS_MODE1_ADDR)
    begin
      s_d.mode1 = (wdata_in & CMS_MODE1_WMASK) | CMS_MODE1_FIXED1;
    end
    if (wr_in && addr_in == CMS_SEL0_ADDR)
    begin
      s_d.sel0 = wdata_in;
    end
    case (addr_in)
      CMS_MODE1_ADDR: s_d.rdata = s_q.mode1;
      CMS_SEL0_ADDR:  s_d.rdata = s_q.sel0;
      default:        s_d.rdata = 8'h00;
    endcase
    s_d.pos = decode(s_d.sel0[3:0], 1'b0);
    s_d.neg = decode(s_d.sel0[7:4], 1'b1);
    s_d.irq = (cmp1_rise_flag_in && s_d.mode1[CMS_RISE_EN_BIT])
            || (cmp1_fall_flag_in && s_d.mode1[CMS_FALL_EN_BIT]);
    s_d.half_en = s_d.pos.half || s_d.neg.half
               || cmp1_sel_in[3:0] == CMS_SEL_HALF || cmp1_sel_in[7:4] == CMS_SEL_HALF;
    s_d.touch_pos = s_d.neg.touch && s_d.pos.pin;
    s_d.touch_neg = s_d.pos.touch && s_d.neg.pin;
    s_d.timer_sel = timer_route_in;
  end

  // State register.
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      s_q       <= '0;
      s_q.mode1 <= CMS_MODE1_RESET;
      s_q.sel0  <= CMS_SEL0_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register.
  always_comb
  begin
    rdata_out              = s_q.rdata;
    cmp1_mode_reg_out      = s_q.mode1;
    cmp0_input_sel_reg_out = s_q.sel0;
    cmp1_irq_out           = s_q.irq;
    half_div_en_out        = s_q.half_en;
    touch_pos_out          = s_q.touch_pos;
    touch_neg_out          = s_q.touch_neg;
    timer_route_out        = s_q.timer_sel;
    pos_pin_out            = {s_q.pos.pin, s_q.pos.pin_idx};
    neg_pin_out            = {s_q.neg.pin, s_q.neg.pin_idx};
  end

  // Checks on the register behaviour.
  property p_bit7_one;
    @(posedge core_clk_in) disable iff (!nrst_in) s_q.mode1[7];
  endproperty
  a_bit7_one: assert property (p_bit7_one) else $error("Mode bit 7 not one.");
  property p_bit6_zero;
    @(posedge core_clk_in) disable iff (!nrst_in) !s_q.mode1[6];
  endproperty
  a_bit6_zero: assert property (p_bit6_zero) else $error("Mode bit 6 not zero.");
  property p_bits32_zero;
    @(posedge core_clk_in) disable iff (!nrst_in) s_q.mode1[3:2] == 2'b00;
  endproperty
  a_bits32_zero: assert property (p_bits32_zero) else $error("Mode bits 3:2 not zero.");
  property p_rise_en;
    @(posedge core_clk_in) disable iff (!nrst_in)
      wr_in && addr_in == CMS_MODE1_ADDR |=> cmp1_mode_reg_out[5] == $past(wdata_in[5]);
  endproperty
  a_rise_en: assert property (p_rise_en) else $error("Rise enable not stored.");
  property p_fall_en;
    @(posedge core_clk_in) disable iff (!nrst_in)
      wr_in && addr_in == CMS_MODE1_ADDR |=> cmp1_mode_reg_out[4] == $past(wdata_in[4]);
  endproperty
  a_fall_en: assert property (p_fall_en) else $error("Fall enable not stored.");
  property p_mode_sel;
    @(posedge core_clk_in) disable iff (!nrst_in)
      wr_in && addr_in == CMS_MODE1_ADDR |=> cmp1_mode_reg_out[1:0] == $past(wdata_in[1:0]);
  endproperty
  a_mode_sel: assert property (p_mode_sel) else $error("Mode select not stored.");
  property p_sel0;
    @(posedge core_clk_in) disable iff (!nrst_in)
      wr_in && addr_in == CMS_SEL0_ADDR |=> cmp0_input_sel_reg_out == $past(wdata_in);
  endproperty
  a_sel0: assert property (p_sel0) else $error("Input select not stored.");
  property p_half;
    @(posedge core_clk_in) disable iff (!nrst_in)
      $past(nrst_in) |-> half_div_en_out == (cmp0_input_sel_reg_out[3:0] == CMS_SEL_HALF
      || cmp0_input_sel_reg_out[7:4] == CMS_SEL_HALF || $past(cmp1_sel_in[3:0]) == CMS_SEL_HALF
      || $past(cmp1_sel_in[7:4]) == CMS_SEL_HALF);
  endproperty
  a_half: assert property (p_half) else $error("Divider enable wrong.");
  property p_touch;
    @(posedge core_clk_in) disable iff (!nrst_in)
      touch_neg_out |-> cmp0_input_sel_reg_out[3:0] == CMS_SEL_TOUCH && neg_pin_out[3];
  endproperty
  a_touch: assert property (p_touch) else $error("Touch sense wrong.");
  property p_irq;
    @(posedge core_clk_in) disable iff (!nrst_in)
      cmp1_rise_flag_in && cmp1_mode_reg_out[5] && !(wr_in && addr_in == CMS_MODE1_ADDR)
      |=> cmp1_irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt missing.");

  // Level, readback, routing and decode checks; all but the reserved-code and touch checks skip the first cycle after reset.
  property p_irq_level;
    @(posedge core_clk_in) disable iff (!nrst_in)
      $past(nrst_in) |-> cmp1_irq_out ==
      (($past(cmp1_rise_flag_in) && cmp1_mode_reg_out[CMS_RISE_EN_BIT])
      || ($past(cmp1_fall_flag_in) && cmp1_mode_reg_out[CMS_FALL_EN_BIT]));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("Interrupt level wrong.");
  property p_timer;
    @(posedge core_clk_in) disable iff (!nrst_in)
      $past(nrst_in) |-> timer_route_out == $past(timer_route_in);
  endproperty
  a_timer: assert property (p_timer) else $error("Timer route not passed.");
  property p_rdata_mode;
    @(posedge core_clk_in) disable iff (!nrst_in)
      $past(nrst_in) && $past(addr_in) == CMS_MODE1_ADDR |-> rdata_out == $past(cmp1_mode_reg_out);
  endproperty
  a_rdata_mode: assert property (p_rdata_mode) else $error("Mode readback wrong.");
  property p_rdata_sel;
    @(posedge core_clk_in) disable iff (!nrst_in)
      $past(nrst_in) && $past(addr_in) == CMS_SEL0_ADDR |-> rdata_out == $past(cmp0_input_sel_reg_out);
  endproperty
  a_rdata_sel: assert property (p_rdata_sel) else $error("Select readback wrong.");
  property p_rdata_none;
    @(posedge core_clk_in) disable iff (!nrst_in)
      $past(nrst_in) && $past(addr_in) != CMS_MODE1_ADDR && $past(addr_in) != CMS_SEL0_ADDR
      |-> rdata_out == 8'h00;
  endproperty
  a_rdata_none: assert property (p_rdata_none) else $error("Unmapped readback not zero.");
  property p_pin_pos;
    @(posedge core_clk_in) disable iff (!nrst_in)
      $past(nrst_in) |-> pos_pin_out ==
      {cmp0_input_sel_reg_out[3:0] <= CMS_SEL_PIN_MAX, cmp0_input_sel_reg_out[2:0]};
  endproperty
  a_pin_pos: assert property (p_pin_pos) else $error("Positive pin route wrong.");
  property p_pin_neg;
    @(posedge core_clk_in) disable iff (!nrst_in)
      $past(nrst_in) |-> neg_pin_out ==
      {cmp0_input_sel_reg_out[7:4] < CMS_NEG_RSV, cmp0_input_sel_reg_out[6:4]};
  endproperty
  a_pin_neg: assert property (p_pin_neg) else $error("Negative pin route wrong.");
  property p_rsvd_pos;
    @(posedge core_clk_in) disable iff (!nrst_in)
      s_q.pos.rsvd |-> !s_q.pos.pin && !s_q.pos.touch && !s_q.pos.half;
  endproperty
  a_rsvd_pos: assert property (p_rsvd_pos) else $error("Reserved positive code routed.");
  property p_rsvd_neg;
    @(posedge core_clk_in) disable iff (!nrst_in)
      s_q.neg.rsvd |-> !s_q.neg.pin && !s_q.neg.touch && !s_q.neg.half;
  endproperty
  a_rsvd_neg: assert property (p_rsvd_neg) else $error("Reserved negative code routed.");
  property p_touch_pos;
    @(posedge core_clk_in) disable iff (!nrst_in)
      touch_pos_out |-> cmp0_input_sel_reg_out[7:4] == CMS_SEL_TOUCH && pos_pin_out[3];
  endproperty
  a_touch_pos: assert property (p_touch_pos) else $error("Positive touch sense wrong.");

  // Main scenarios that the bench is expected to reach.
  c_irq: cover property (@(posedge core_clk_in) disable iff (!nrst_in) cmp1_irq_out);
  c_half: cover property (@(posedge core_clk_in) disable iff (!nrst_in) half_div_en_out);
  c_touch: cover property (@(posedge core_clk_in) disable iff (!nrst_in) touch_pos_out);
  c_touch_neg: cover property (@(posedge core_clk_in) disable iff (!nrst_in) touch_neg_out);
  c_rsvd: cover property (@(posedge core_clk_in) disable iff (!nrst_in) s_q.neg.rsvd || s_q.pos.rsvd);
endmodule
`default_nettype wire

/* src/cms_pkg.sv */
/*
  Constants and carrier types for the comparator mode and input select bank.
  Assumes an 8-bit special-function register bus with a one-cycle write strobe.
*/
package cms_pkg;
  localparam logic [7:0] CMS_MODE1_ADDR   = 8'h9c;
  localparam logic [7:0] CMS_SEL0_ADDR    = 8'h9f;
  localparam logic [7:0] CMS_MODE1_RESET  = 8'h82;
  localparam logic [7:0] CMS_SEL0_RESET   = 8'hff;
  localparam logic [7:0] CMS_MODE1_FIXED1 = 8'h80;
  localparam logic [7:0] CMS_MODE1_WMASK  = 8'h33;
  localparam int         CMS_RISE_EN_BIT  = 5;
  localparam int         CMS_FALL_EN_BIT  = 4;
  localparam logic [3:0] CMS_SEL_TOUCH    = 4'hc;
  localparam logic [3:0] CMS_SEL_HALF     = 4'hd;
  localparam logic [3:0] CMS_SEL_PIN_MAX  = 4'h7;
  localparam logic [3:0] CMS_NEG_RSV      = 4'h7;

  // Decoded routing state of one multiplexer.
  typedef struct packed {
    logic       pin;
    logic [2:0] pin_idx;
    logic       touch;
    logic       half;
    logic       rsvd;
  } cms_route_t;

  // Whole register state.
  typedef struct packed {
    logic [7:0] mode1;
    logic [7:0] sel0;
    logic [7:0] rdata;
    logic       irq;
    logic       half_en;
    logic       touch_pos;
    logic       touch_neg;
    logic [1:0] timer_sel;
    cms_route_t pos;
    cms_route_t neg;
  } cms_state_t;
endpackage

/* verif/testbench.sv */
/*
  Self-checking bench for the comparator mode and input select bank.
  Assumes cms_regs answers a read one cycle after the address is shown.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench
  import cms_pkg::*;
;
  logic        core_clk_in = 1'b0;
  logic        nrst_in     = 1'b0;
  logic [7:0]  addr_in     = 8'h00;
  logic        wr_in       = 1'b0;
  logic [7:0]  wdata_in    = 8'h00;
  logic        rise_in     = 1'b0;
  logic        fall_in     = 1'b0;
  logic [7:0]  sel1_in     = 8'h00;
  logic [1:0]  route_in    = 2'b00;
  logic [7:0]  rdata, mode_o, sel_o, mode_m = 8'h82, sel_m = 8'hff;
  logic        irq, half, tpos, tneg, pend = 1'b0, pend_q = 1'b0;
  logic [1:0]  route;
  logic [3:0]  ppin, npin;
  logic [37:0] exp_q[$];
  logic [37:0] exp, got;
  integer      seed = 27254;
  int          error_cnt = 0;
  int          n_tests = 0;

  // The clock toggles every half period of 12.5 ns.
  always #12.5 core_clk_in = ~core_clk_in;

  cms_regs dut (
    .core_clk_in            (core_clk_in),
    .nrst_in                (nrst_in),
    .addr_in                (addr_in),
    .wr_in                  (wr_in),
    .wdata_in               (wdata_in),
    .rdata_out              (rdata),
    .cmp1_rise_flag_in      (rise_in),
    .cmp1_fall_flag_in      (fall_in),
    .cmp1_sel_in            (sel1_in),
    .timer_route_in         (route_in),
    .cmp1_mode_reg_out      (mode_o),
    .cmp0_input_sel_reg_out (sel_o),
    .cmp1_irq_out           (irq),
    .half_div_en_out        (half),
    .touch_pos_out          (tpos),
    .touch_neg_out          (tneg),
    .timer_route_out        (route),
    .pos_pin_out            (ppin),
    .neg_pin_out            (npin)
  );
  assign got = {mode_o, sel_o, ppin, npin, route, irq, half, tpos, tneg, rdata};

  // Works out every output expected after a read of address a.
  function automatic logic [37:0] expect_word(input logic [7:0] a);
    logic [7:0] rd;
    logic [3:0] pn;
    logic [3:0] ng;
    rd = (a == CMS_MODE1_ADDR) ? mode_m : (a == CMS_SEL0_ADDR) ? sel_m : 8'h00;
    pn = sel_m[3:0];
    ng = sel_m[7:4];
    return {mode_m, sel_m, pn <= 4'h7, pn[2:0], ng <= 4'h6, ng[2:0],
            route_in, (rise_in & mode_m[5]) | (fall_in & mode_m[4]),
            pn == 4'hd || ng == 4'hd || sel1_in[3:0] == 4'hd || sel1_in[7:4] == 4'hd,
            ng == 4'hc && pn <= 4'h7, pn == 4'hc && ng <= 4'h6, rd};
  endfunction

  // Drives one write strobe and updates the register model.
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    addr_in  <= a;
    wr_in    <= 1'b1;
    wdata_in <= d;
    @(posedge core_clk_in);
    wr_in    <= 1'b0;
    if (a == CMS_MODE1_ADDR) mode_m = (d & 8'h33) | 8'h80;
    if (a == CMS_SEL0_ADDR) sel_m = d;
  endtask

  // Presents an address and notes the expected answer.
  task automatic bus_read(input logic [7:0] a);
    @(posedge core_clk_in);
    addr_in <= a;
    pend    <= 1'b1;
    exp_q.push_back(expect_word(a));
    @(posedge core_clk_in);
    pend    <= 1'b0;
  endtask

  // Prints the verdict and stops the run.
  task automatic summarize();
    if (error_cnt == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Compares each answer with the oldest note once it has settled.
  always @(posedge core_clk_in) pend_q <= pend;
  always @(negedge core_clk_in)
  begin
    if (pend_q && exp_q.size() > 0)
    begin
      exp = exp_q.pop_front();
      n_tests++;
      if (got !== exp)
      begin
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        error_cnt++;
      end
    end
  end

  // Main sequence: reset values, then random writes and readback.
  initial
  begin
    repeat (20) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    bus_read(CMS_MODE1_ADDR);
    bus_read(CMS_SEL0_ADDR);
    repeat (200)
    begin
      @(posedge core_clk_in);
      rise_in  <= 1'($random(seed));
      fall_in  <= 1'($random(seed));
      sel1_in  <= 8'($random(seed));
      route_in <= 2'($random(seed));
      bus_write(CMS_MODE1_ADDR, 8'($random(seed)) | 8'h80);
      bus_write(CMS_SEL0_ADDR, 8'($random(seed)));
      bus_write(8'h9d, 8'($random(seed)));
      bus_read(CMS_MODE1_ADDR);
      bus_read(CMS_SEL0_ADDR);
      bus_read(8'h9d);
    end
    summarize();
  end

  // Watchdog cuts a hang short well after the expected run length.
  initial
  begin
    #200000;
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
